//--- logic/ofp_defs.svh
`ifndef OFP_DEFS_SVH
`define OFP_DEFS_SVH

// ****************************************
// clock and time base
// ****************************************
`define OFP_CLK_HZ 125000000
`define OFP_TICK_US 1000
`define OFP_TICK_CYC (`OFP_CLK_HZ / 1000 * `OFP_TICK_US / 1000)

// ****************************************
// fixed start delays of the high-set stages, in ms
// ****************************************
`define OFP_PH_HIGH_START_MS 40
`define OFP_EF_HIGH_START_MS 50

// ****************************************
// inverse curves: base operate time in ms at k = 1.0,
// entry 0 (low bits) at 1.5x, then 2x, 3x, 5x, 10x, 20x
// ****************************************
`define OFP_MULT_HALVES {6'h28, 6'h14, 6'h0A, 6'h06, 6'h04, 6'h03}
`define OFP_CURVE_NORMAL {20'h008DE, 20'h00B9A, 20'h010B8, \
  20'h0189C, 20'h02710, 20'h04330}
`define OFP_CURVE_VERY {20'h002C6, 20'h005DC, 20'h00D34, \
  20'h01A5E, 20'h034BC, 20'h06978}
`define OFP_CURVE_EXTREME {20'h000C8, 20'h0032A, 20'h00D02, \
  20'h02710, 20'h0684C, 20'h0FA00}
`define OFP_CURVE_LONG {20'h0189C, 20'h033F4, 20'h07530, \
  20'h0EA60, 20'h1D4C0, 20'h3A980}
`define OFP_CURVE_MAKER_A {20'h00BF4, 20'h00C62, 20'h00D66, \
  20'h00F0A, 20'h011A8, 20'h01572}
`define OFP_CURVE_MAKER_B {20'h006E0, 20'h00A82, 20'h00E2E, \
  20'h010E0, 20'h012FC, 20'h01482}

`endif

//--- logic/ofp_pkg.sv
package ofp_pkg;
  typedef enum logic [2:0] {
    OFP_CURVE_NORMAL_INV = 3'b000,
    OFP_CURVE_VERY_INV = 3'b001,
    OFP_CURVE_EXTREME_INV = 3'b010,
    OFP_CURVE_LONG_INV = 3'b011,
    OFP_CURVE_MAKER_A = 3'b100,
    OFP_CURVE_MAKER_B = 3'b101
  } ofp_curve_t;
  typedef enum logic {
    OFP_CHAR_DEFINITE = 1'b0,
    OFP_CHAR_INVERSE = 1'b1
  } ofp_char_t;
  typedef enum logic {
    OFP_HS_INSTANT = 1'b0,
    OFP_HS_DEFINITE = 1'b1
  } ofp_hs_mode_t;
  typedef enum logic [1:0] {
    OFP_ST_IDLE = 2'b00,
    OFP_ST_STARTED = 2'b01,
    OFP_ST_OPERATED = 2'b10
  } ofp_state_t;
endpackage

//--- logic/ofp_stage_if.sv
`timescale 1ns/1ns
interface ofp_stage_if;
  logic pickup;
  logic tick;
  logic [23:0] startMs;
  logic [23:0] operateMs;
  logic started;
  logic startOut;
  logic operate;
  modport stg (input pickup, tick, startMs, operateMs,
    output started, startOut, operate);
  modport ctl (output pickup, tick, startMs, operateMs,
    input started, startOut, operate);
endinterface

//--- logic/ofp_idmt.sv
`timescale 1ns/1ns
`include "ofp_defs.svh"
module ofp_idmt (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] current, // measured current
  input wire logic [15:0] threshold, // start threshold
  input wire ofp_pkg::ofp_curve_t curve, // curve set
  input wire logic [7:0] kMul, // time multiplier, 1/16 steps
  output logic [23:0] operateMs // computed operate time
);
  localparam logic [35:0] MULTS = `OFP_MULT_HALVES;
  logic [5:0] over;
  logic [2:0] band;
  logic [119:0] table_;
  logic [19:0] baseMs;
  logic [27:0] product;

  // ****************************************
  // current multiple band
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gBand
      assign over[g] = {5'h00, current, 1'b0} >=
        ({6'h00, threshold} * {16'h0000, MULTS[g*6 +: 6]});
    end
  endgenerate

  // below 1.5x the 1.5x time is used, which is early there; from 1.5x up it is slow but never early
  always_comb begin
    band = 3'h0;
    for (int i = 1; i < 6; i++) begin
      if (over[i]) begin
        band = 3'(i);
      end
    end
  end

  // ****************************************
  // curve table and multiplier
  // ****************************************
  always_comb begin
    case (curve)
      ofp_pkg::OFP_CURVE_NORMAL_INV: table_ = `OFP_CURVE_NORMAL;
      ofp_pkg::OFP_CURVE_VERY_INV: table_ = `OFP_CURVE_VERY;
      ofp_pkg::OFP_CURVE_EXTREME_INV: table_ = `OFP_CURVE_EXTREME;
      ofp_pkg::OFP_CURVE_LONG_INV: table_ = `OFP_CURVE_LONG;
      ofp_pkg::OFP_CURVE_MAKER_A: table_ = `OFP_CURVE_MAKER_A;
      ofp_pkg::OFP_CURVE_MAKER_B: table_ = `OFP_CURVE_MAKER_B;
      default: table_ = `OFP_CURVE_NORMAL;
    endcase
  end

  assign baseMs = table_[band*20 +: 20];
  assign product = {8'h00, baseMs} * {20'h00000, kMul};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      operateMs <= 24'h000000;
    end else begin
      operateMs <= product[27:4];
    end
  end
endmodule

//--- logic/ofp_stage.sv
`timescale 1ns/1ns
module ofp_stage (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  ofp_stage_if.stg s // stage control and results
);
  ofp_pkg::ofp_state_t state_reg;
  ofp_pkg::ofp_state_t state_next;
  logic [23:0] elapsed_reg;
  logic startedReg;
  logic startOutReg;
  logic operateReg;

  // ****************************************
  // stage sequence
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ofp_pkg::OFP_ST_IDLE: begin
        if (s.pickup) begin
          state_next = ofp_pkg::OFP_ST_STARTED;
        end
      end
      ofp_pkg::OFP_ST_STARTED: begin
        if (!s.pickup) begin
          state_next = ofp_pkg::OFP_ST_IDLE;
        end else if (elapsed_reg >= s.operateMs) begin
          state_next = ofp_pkg::OFP_ST_OPERATED;
        end
      end
      ofp_pkg::OFP_ST_OPERATED: begin
        if (!s.pickup) begin
          state_next = ofp_pkg::OFP_ST_IDLE;
        end
      end
      default: state_next = ofp_pkg::OFP_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ofp_pkg::OFP_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ms since start; cleared whenever the stage drops out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_reg <= 24'h000000;
    end else if (state_next == ofp_pkg::OFP_ST_IDLE) begin
      elapsed_reg <= 24'h000000;
    end else if (s.tick && elapsed_reg != 24'hFFFFFF) begin
      elapsed_reg <= elapsed_reg + 24'h000001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      startedReg <= 1'b0;
      startOutReg <= 1'b0;
      operateReg <= 1'b0;
    end else begin
      startedReg <= state_next != ofp_pkg::OFP_ST_IDLE;
      startOutReg <= state_next != ofp_pkg::OFP_ST_IDLE &&
        elapsed_reg >= s.startMs;
      operateReg <= state_next == ofp_pkg::OFP_ST_OPERATED;
    end
  end

  assign s.started = startedReg;
  assign s.startOut = startOutReg;
  assign s.operate = operateReg;

  property p_start_needs_started;
    @(posedge mclk) disable iff (!rst_n)
    startOutReg |-> startedReg && $past(elapsed_reg) >= $past(s.startMs);
  endproperty
  a_start_needs_started: assert property (p_start_needs_started)
    else $error("start output without elapsed start delay");
endmodule

//--- logic/ofp_top.sv
`timescale 1ns/1ns
`include "ofp_defs.svh"
module ofp_top #(
  parameter int TICK_CYCLES = `OFP_TICK_CYC // clocks per ms tick
) (
  input wire logic mclk, // 125 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] phaseA, // phase A current
  input wire logic [15:0] phaseB, // phase B current
  input wire logic [15:0] phaseC, // phase C current
  input wire logic [15:0] neutral, // neutral current
  input wire logic [15:0] phLowThr, // low phase threshold
  input wire logic [15:0] phLowStartMs, // low phase start delay
  input wire logic [15:0] phLowOpMs, // low phase definite time
  input wire ofp_pkg::ofp_char_t phLowChar, // low phase characteristic
  input wire ofp_pkg::ofp_curve_t phLowCurve, // low phase curve
  input wire logic [7:0] phLowK, // low phase multiplier
  input wire logic [15:0] phHighThr, // high phase threshold
  input wire logic [15:0] phHighOpMs, // high phase operate time
  input wire ofp_pkg::ofp_hs_mode_t phHighMode, // high phase mode
  input wire logic [15:0] efLowThr, // low earth threshold
  input wire logic [15:0] efLowStartMs, // low earth start delay
  input wire logic [15:0] efLowOpMs, // low earth definite time
  input wire ofp_pkg::ofp_char_t efLowChar, // low earth characteristic
  input wire ofp_pkg::ofp_curve_t efLowCurve, // low earth curve
  input wire logic [7:0] efLowK, // low earth multiplier
  input wire logic [15:0] efHighThr, // high earth threshold
  input wire logic [15:0] efHighOpMs, // high earth operate time
  input wire ofp_pkg::ofp_hs_mode_t efHighMode, // high earth mode
  output logic [3:0] stageStarted, // started state per stage
  output logic [3:0] stageStart, // start signal per stage
  output logic [3:0] stageOperate, // operate signal per stage
  output logic trip // any stage operated
);
  localparam int PH_LOW = 0;
  localparam int PH_HIGH = 1;
  localparam int EF_LOW = 2;
  localparam int EF_HIGH = 3;

  logic [16:0] tickCnt_reg;
  logic tick_reg;
  logic [15:0] curA_reg;
  logic [15:0] curB_reg;
  logic [15:0] curC_reg;
  logic [15:0] curN_reg;
  logic [15:0] maxPh_reg;
  logic [15:0] maxAB;
  logic [15:0] maxPh_next;
  logic [3:0] pick_reg;
  logic [3:0] pick_next;
  logic [23:0] phLowIdmtMs;
  logic [23:0] efLowIdmtMs;
  logic [23:0] opMs_reg [4];
  logic [23:0] startMs [4];
  logic [3:0] startedW;
  logic [3:0] startW;
  logic [3:0] operateW;
  logic trip_reg;

  // ****************************************
  // ms time base
  // ****************************************
  // one shared tick keeps all stage timers in step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end else if (tickCnt_reg == 17'(TICK_CYCLES - 1)) begin
      tickCnt_reg <= 17'h00000;
      tick_reg <= 1'b1;
    end else begin
      tickCnt_reg <= tickCnt_reg + 17'h00001;
      tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // measured currents
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      curA_reg <= 16'h0000;
      curB_reg <= 16'h0000;
      curC_reg <= 16'h0000;
      curN_reg <= 16'h0000;
    end else begin
      curA_reg <= phaseA;
      curB_reg <= phaseB;
      curC_reg <= phaseC;
      curN_reg <= neutral;
    end
  end

  // worst phase drives the inverse time
  assign maxAB = (curA_reg > curB_reg) ? curA_reg : curB_reg;
  assign maxPh_next = (maxAB > curC_reg) ? maxAB : curC_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      maxPh_reg <= 16'h0000;
    end else begin
      maxPh_reg <= maxPh_next;
    end
  end

  // ****************************************
  // threshold comparison
  // ****************************************
  always_comb begin
    pick_next[PH_LOW] = curA_reg > phLowThr || curB_reg > phLowThr ||
      curC_reg > phLowThr;
    pick_next[PH_HIGH] = curA_reg > phHighThr ||
      curB_reg > phHighThr || curC_reg > phHighThr;
    pick_next[EF_LOW] = curN_reg > efLowThr;
    pick_next[EF_HIGH] = curN_reg > efHighThr;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pick_reg <= 4'h0;
    end else begin
      pick_reg <= pick_next;
    end
  end

  // ****************************************
  // inverse time calculators
  // ****************************************
  ofp_idmt uPhIdmt (
    .mclk(mclk),
    .rst_n(rst_n),
    .current(maxPh_reg),
    .threshold(phLowThr),
    .curve(phLowCurve),
    .kMul(phLowK),
    .operateMs(phLowIdmtMs)
  );

  ofp_idmt uEfIdmt (
    .mclk(mclk),
    .rst_n(rst_n),
    .current(curN_reg),
    .threshold(efLowThr),
    .curve(efLowCurve),
    .kMul(efLowK),
    .operateMs(efLowIdmtMs)
  );

  // ****************************************
  // delay selection
  // ****************************************
  assign startMs[PH_LOW] = {8'h00, phLowStartMs};
  assign startMs[PH_HIGH] = 24'(`OFP_PH_HIGH_START_MS);
  assign startMs[EF_LOW] = {8'h00, efLowStartMs};
  assign startMs[EF_HIGH] = 24'(`OFP_EF_HIGH_START_MS);

  // inverse time follows the current as it changes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opMs_reg[PH_LOW] <= 24'h000000;
      opMs_reg[PH_HIGH] <= 24'h000000;
      opMs_reg[EF_LOW] <= 24'h000000;
      opMs_reg[EF_HIGH] <= 24'h000000;
    end else begin
      opMs_reg[PH_LOW] <= (phLowChar == ofp_pkg::OFP_CHAR_INVERSE) ?
        phLowIdmtMs : {8'h00, phLowOpMs};
      opMs_reg[PH_HIGH] <= (phHighMode == ofp_pkg::OFP_HS_INSTANT) ?
        24'h000000 : {8'h00, phHighOpMs};
      opMs_reg[EF_LOW] <= (efLowChar == ofp_pkg::OFP_CHAR_INVERSE) ?
        efLowIdmtMs : {8'h00, efLowOpMs};
      opMs_reg[EF_HIGH] <= (efHighMode == ofp_pkg::OFP_HS_INSTANT) ?
        24'h000000 : {8'h00, efHighOpMs};
    end
  end

  // ****************************************
  // stages
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gStage
      ofp_stage_if sif ();
      logic [23:0] runMs;

      assign sif.pickup = pick_reg[g];
      assign sif.tick = tick_reg;
      assign sif.startMs = startMs[g];
      assign sif.operateMs = opMs_reg[g];
      assign startedW[g] = sif.started;
      assign startW[g] = sif.startOut;
      assign operateW[g] = sif.operate;

      ofp_stage uStage (
        .mclk(mclk),
        .rst_n(rst_n),
        .s(sif)
      );

      // mirror of the stage timer, read only by checks
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          runMs <= 24'h000000;
        end else if (!pick_reg[g]) begin
          runMs <= 24'h000000;
        // counts from the pickup edge, as the stage timer does
        end else if (tick_reg && runMs != 24'hFFFFFF) begin
          runMs <= runMs + 24'h000001;
        end
      end

      property p_start_delay;
        @(posedge mclk) disable iff (!rst_n)
        $rose(startW[g]) |-> runMs >= startMs[g];
      endproperty
      a_start_delay: assert property (p_start_delay)
        else $error("start output before start delay");

      property p_operate_delay;
        @(posedge mclk) disable iff (!rst_n)
        $rose(operateW[g]) |-> runMs >= $past(opMs_reg[g]);
      endproperty
      a_operate_delay: assert property (p_operate_delay)
        else $error("operate before operate delay");

      property p_drop_clear;
        @(posedge mclk) disable iff (!rst_n)
        !pick_reg[g] |=> !startedW[g] && !startW[g] && !operateW[g];
      endproperty
      a_drop_clear: assert property (p_drop_clear)
        else $error("stage held after current dropped");
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trip_reg <= 1'b0;
    end else begin
      trip_reg <= |operateW;
    end
  end

  assign stageStarted = startedW;
  assign stageStart = startW;
  assign stageOperate = operateW;
  assign trip = trip_reg;

  // ****************************************
  // checks
  // ****************************************
  property p_ph_low_pick;
    @(posedge mclk) disable iff (!rst_n)
    (curA_reg > phLowThr && $stable(phLowThr)) |=> pick_reg[PH_LOW]
      ##1 stageStarted[PH_LOW] || !pick_reg[PH_LOW];
  endproperty
  a_ph_low_pick: assert property (p_ph_low_pick)
    else $error("low phase stage did not start");

  property p_ef_low_pick;
    @(posedge mclk) disable iff (!rst_n)
    (curN_reg > efLowThr && $stable(efLowThr)) |=> pick_reg[EF_LOW];
  endproperty
  a_ef_low_pick: assert property (p_ef_low_pick)
    else $error("low earth stage did not pick up");

  property p_hs_instant;
    @(posedge mclk) disable iff (!rst_n)
    (phHighMode == ofp_pkg::OFP_HS_INSTANT) |=>
      opMs_reg[PH_HIGH] == 24'h000000;
  endproperty
  a_hs_instant: assert property (p_hs_instant)
    else $error("instantaneous high stage has a delay");

  property p_ef_low_definite;
    @(posedge mclk) disable iff (!rst_n)
    (efLowChar == ofp_pkg::OFP_CHAR_DEFINITE) |=>
      opMs_reg[EF_LOW] == {8'h00, $past(efLowOpMs)};
  endproperty
  a_ef_low_definite: assert property (p_ef_low_definite)
    else $error("definite time not taken from setting");
endmodule

//--- verification/ofp_front_end.sv
`timescale 1ns/1ns
module ofp_front_end (
  input wire logic rst_n, // async reset, active low
  output logic [15:0] phaseA, // phase A magnitude
  output logic [15:0] phaseB, // phase B magnitude
  output logic [15:0] phaseC, // phase C magnitude
  output logic [15:0] neutral // neutral magnitude
);
  // ****************************************
  // measured magnitudes
  // ****************************************
  // a real front end reads zero while held in reset
  initial begin
    phaseA = 16'h0000;
    phaseB = 16'h0000;
    phaseC = 16'h0000;
    neutral = 16'h0000;
  end

  always @(negedge rst_n) begin
    phaseA <= 16'h0000;
    phaseB <= 16'h0000;
    phaseC <= 16'h0000;
    neutral <= 16'h0000;
  end

  // caller is on a rising edge, so the new level lands after it
  task automatic set_level(input int ch, input logic [15:0] val);
    case (ch)
      0: phaseA <= val;
      1: phaseB <= val;
      2: phaseC <= val;
      default: neutral <= val;
    endcase
  endtask
endmodule

//--- verification/ofp_top_bench.sv
`timescale 1ns/1ns
module ofp_top_bench;
  localparam int TK = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] phaseA, phaseB, phaseC, neutral;
  logic [15:0] phLowThr = 16'h0064;
  logic [15:0] phLowStartMs = 16'h0002;
  logic [15:0] phLowOpMs = 16'h0005;
  ofp_pkg::ofp_char_t phLowChar = ofp_pkg::OFP_CHAR_DEFINITE;
  ofp_pkg::ofp_curve_t phLowCurve = ofp_pkg::OFP_CURVE_NORMAL_INV;
  logic [7:0] phLowK = 8'h01;
  logic [15:0] phHighThr = 16'h01F4;
  logic [15:0] phHighOpMs = 16'h003C;
  ofp_pkg::ofp_hs_mode_t phHighMode = ofp_pkg::OFP_HS_DEFINITE;
  logic [15:0] efLowThr = 16'h0032;
  logic [15:0] efLowStartMs = 16'h0003;
  logic [15:0] efLowOpMs = 16'h0008;
  ofp_pkg::ofp_char_t efLowChar = ofp_pkg::OFP_CHAR_DEFINITE;
  ofp_pkg::ofp_curve_t efLowCurve = ofp_pkg::OFP_CURVE_MAKER_B;
  logic [7:0] efLowK = 8'h02;
  logic [15:0] efHighThr = 16'h012C;
  logic [15:0] efHighOpMs = 16'h0046;
  ofp_pkg::ofp_hs_mode_t efHighMode = ofp_pkg::OFP_HS_DEFINITE;
  logic [3:0] stageStarted, stageStart, stageOperate;
  logic trip;
  int nErrors = 0;
  int cmpCount = 0;
  int tStarted, tStart, tOp;
  int invMs[6] = '{2270, 710, 200, 6300, 3060, 1760};

  always #4 mclk = ~mclk;

  ofp_top #(.TICK_CYCLES(TK)) u_ofp_top (
    .mclk(mclk), .rst_n(rst_n), .phaseA(phaseA), .phaseB(phaseB),
    .phaseC(phaseC), .neutral(neutral), .phLowThr(phLowThr),
    .phLowStartMs(phLowStartMs), .phLowOpMs(phLowOpMs),
    .phLowChar(phLowChar), .phLowCurve(phLowCurve), .phLowK(phLowK),
    .phHighThr(phHighThr), .phHighOpMs(phHighOpMs),
    .phHighMode(phHighMode), .efLowThr(efLowThr),
    .efLowStartMs(efLowStartMs), .efLowOpMs(efLowOpMs),
    .efLowChar(efLowChar), .efLowCurve(efLowCurve), .efLowK(efLowK),
    .efHighThr(efHighThr), .efHighOpMs(efHighOpMs),
    .efHighMode(efHighMode), .stageStarted(stageStarted),
    .stageStart(stageStart), .stageOperate(stageOperate), .trip(trip)
  );

  ofp_front_end u_ofp_front_end (
    .rst_n(rst_n), .phaseA(phaseA), .phaseB(phaseB), .phaseC(phaseC),
    .neutral(neutral)
  );

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic check(input int got, input int lo, input int hi);
    cmpCount++;
    if (got < lo || got > hi) begin
      nErrors++;
      $display("wrong value at %0t: got %0h expected %0h..%0h",
        $time, got, lo, hi);
    end
  endtask

  task automatic check_bits(input logic [3:0] got, input logic [3:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // a delay of d ms may land anywhere from d-1 to d+1 ticks after start
  task automatic chk_delay(input int got, input int d);
    check(got, 3 + (d - 1) * TK, 6 + (d + 1) * TK);
  endtask

  task automatic drive(input int ch, input logic [15:0] val);
    @(posedge mclk);
    u_ofp_front_end.set_level(ch, val);
  endtask

  task automatic time_stage(input int st, input int ch,
      input logic [15:0] val);
    tStarted = -1;
    tStart = -1;
    tOp = -1;
    drive(ch, val);
    for (int n = 1; n <= 5000 && tOp < 0; n++) begin
      @(posedge mclk);
      #1;
      if (tStarted < 0 && stageStarted[st] === 1'b1) tStarted = n;
      if (tStart < 0 && stageStart[st] === 1'b1) tStart = n;
      if (stageOperate[st] === 1'b1) tOp = n;
    end
    check(tOp, 0, 5000);
  endtask

  task automatic release_ch(input int ch);
    drive(ch, 16'h0000);
    repeat (3) @(posedge mclk);
    #1;
    check_bits(stageStarted | stageStart | stageOperate, 4'h0);
    @(posedge mclk);
    #1;
    check_bits({3'h0, trip}, 4'h0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_low_definite();
    drive(0, 16'h0064);
    repeat (10) @(posedge mclk);
    #1;
    check_bits(stageStarted, 4'h0);
    time_stage(0, 0, 16'h0065);
    check(tStarted, 3, 3);
    chk_delay(tStart, 2);
    chk_delay(tOp, 5);
    @(posedge mclk);
    #1;
    check_bits({3'h0, trip}, 4'h1);
    release_ch(0);
    $display("test low definite done");
  endtask

  task automatic test_low_inverse();
    int e;
    for (int c = 0; c < 6; c++) begin
      @(posedge mclk);
      phLowChar <= ofp_pkg::OFP_CHAR_INVERSE;
      phLowCurve <= ofp_pkg::ofp_curve_t'(c[2:0]);
      e = invMs[c] / 16;
      time_stage(0, 1, 16'h07D0);
      check(tOp, 3 + (e - 2) * TK, 6 + (e + 2) * TK);
      release_ch(1);
    end
    @(posedge mclk);
    phLowChar <= ofp_pkg::OFP_CHAR_DEFINITE;
    $display("test low inverse done");
  endtask

  task automatic test_high_phase();
    time_stage(1, 2, 16'h0258);
    check(tStarted, 3, 3);
    chk_delay(tStart, 40);
    chk_delay(tOp, 60);
    release_ch(2);
    @(posedge mclk);
    phHighMode <= ofp_pkg::OFP_HS_INSTANT;
    time_stage(1, 0, 16'h0258);
    check(tOp, tStarted + 1, tStarted + 1);
    release_ch(0);
    $display("test high phase done");
  endtask

  task automatic test_earth();
    time_stage(2, 3, 16'h003C);
    check(tStarted, 3, 3);
    chk_delay(tStart, 3);
    chk_delay(tOp, 8);
    release_ch(3);
    @(posedge mclk);
    efLowChar <= ofp_pkg::OFP_CHAR_INVERSE;
    // 10x band of the second maker curve, multiplier of 2/16
    time_stage(2, 3, 16'h01F4);
    check(tOp, 3 + 334 * TK, 6 + 338 * TK);
    release_ch(3);
    time_stage(3, 3, 16'h0190);
    chk_delay(tStart, 50);
    chk_delay(tOp, 70);
    release_ch(3);
    @(posedge mclk);
    efHighMode <= ofp_pkg::OFP_HS_INSTANT;
    time_stage(3, 3, 16'h0190);
    check(tOp, tStarted + 1, tStarted + 1);
    release_ch(3);
    $display("test earth done");
  endtask

  // a timer left running would operate well before the full delay
  task automatic test_drop_midway();
    drive(0, 16'h0065);
    repeat (3 + 3 * TK) @(posedge mclk);
    release_ch(0);
    time_stage(0, 0, 16'h0065);
    chk_delay(tOp, 5);
    release_ch(0);
    $display("test drop midway done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    test_low_definite();
    test_low_inverse();
    test_high_phase();
    test_earth();
    test_drop_midway();
    tally_and_finish();
  end

  // whole run is near 5700 cycles; allow about 14 times that
  initial begin
    #640000;
    nErrors++;
    $display("watchdog expired at %0t", $time);
    tally_and_finish();
  end
endmodule
